// ==== ctm_pkg.sv ====
// Purpose: Shared constants and types for the condition monitor teach control block
// Assumes: 40 MHz system clock, classic Wishbone register access with byte addresses
// Notes: Hold and tick counts above 4096 cycles are also top-level parameters
package ctm_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int LONG_HOLD_MS = 3000;
    localparam int SHORT_HOLD_MS = 1000;
    localparam int TICK_MS = 50;
    localparam int LONG_HOLD_CYC = (CLK_HZ / 1000) * LONG_HOLD_MS;
    localparam int SHORT_HOLD_CYC = (CLK_HZ / 1000) * SHORT_HOLD_MS;
    localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
    localparam int HOLD_W = 27;

    localparam logic [7:0] ADDR_SETTINGS = 8'h00;
    localparam logic [7:0] ADDR_CYCLE = 8'h04;
    localparam logic [7:0] ADDR_SENS = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CRIT = 8'h10;
    localparam logic [7:0] ADDR_WARN = 8'h14;
    localparam logic [7:0] ADDR_SELECT = 8'h18;

    localparam int SET_WIRING_LSB = 0;
    localparam int SET_CUR_LSB = 4;
    localparam int SET_VOLT_LSB = 8;
    localparam int SET_ATYPE_BIT = 12;

    localparam logic [1:0] THREE_PHASE_THREE_WIRE_TWO_METER = 2'h0;
    localparam logic [1:0] THREE_PHASE_FOUR_WIRE = 2'h1;
    localparam logic [1:0] SINGLE_PHASE_CURRENT = 2'h2;
    // Current codes 0..4 are 5, 25, 100, 200, 400 A; voltage codes 0..2 are 150, 300, 600 V
    localparam logic [2:0] CUR_CODE_MAX = 3'h4;
    localparam logic [1:0] VOLT_CODE_MAX = 2'h2;

    localparam logic [1:0] WIRING_RST = 2'h0;
    localparam logic [2:0] CUR_RST = 3'h0;
    localparam logic [1:0] VOLT_RST = 2'h0;
    localparam logic ATYPE_RST = 1'b0;
    localparam logic [10:0] CYCLE_MIN = 11'h001;
    localparam logic [10:0] CYCLE_MAX = 11'h7D0;
    localparam logic [10:0] CYCLE_RST = 11'h001;
    localparam logic [7:0] SENS_MIN = 8'h14;
    localparam logic [7:0] SENS_MAX = 8'hC8;
    localparam logic [7:0] SENS_RST = 8'h50;
    localparam logic [23:0] PERCENT_DIV = 24'h000064;

    localparam int FEAT_N = 4;
    localparam int FEAT_W = 16;

    typedef enum logic {LVL_OPERATION, LVL_SETTING} ctm_level_e;
    typedef enum logic [1:0] {TCH_IDLE, TCH_NORMAL, TCH_ABNORMAL, TCH_DONE} ctm_teach_e;

endpackage

// ==== ctm_teach_control.sv ====
// Purpose: Front-panel level navigation, input settings, teaching and alarm status mapping
// Assumes: Keys are asynchronous active-high pins; features arrive on clk_i with a valid pulse
// Notes: Settings other than alarm type and the two thresholds are only accepted while in the setting level
// Function
// - Level key 3 s enters setting level
// - Level key 1 s: soft reset, monitoring
// - Wiring setting holds three encoded choices
// - Current range among five values
// - Voltage range among three values
// - Feature cycle 1..2000 of 50 ms
// - Sensitivity 20..200 percent, default 80
// - Smaller sensitivity alarms earlier
// - Alarm type changed by tool only
// - Normal key 3 s starts teaching
// - Normal lamp lit only on success
// - Abnormal acquisition runs until completion
// - Set key completes, swaps the lamps
// - Pick largest change, threshold from it
// - Critical and warning thresholds start equal
// - Warning: yellow, alarm 2; normal: green
// - Critical: red and alarm 1
// - Judgment only after teaching completes
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ctm_teach_control import ctm_pkg::*; #(
    parameter int LONG_HOLD_CYCLES = LONG_HOLD_CYC,
    parameter int SHORT_HOLD_CYCLES = SHORT_HOLD_CYC,
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic level_key_i,
    input wire logic normal_key_i,
    input wire logic set_key_i,
    input wire logic feat_valid_i,
    input wire logic [FEAT_N-1:0][FEAT_W-1:0] feat_i,
    output logic setting_level_o,
    output logic soft_reset_o,
    output logic normal_capture_key_lamp_o,
    output logic teach_success_lamp_o,
    output logic lamp_green_o,
    output logic lamp_yellow_o,
    output logic lamp_red_o,
    output logic alarm_out1_o,
    output logic alarm_out2_o
);

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return r;
    endfunction

    ctm_level_e level;
    ctm_teach_e teach;
    logic [2:0] key_meta;
    logic [2:0] key_sync;
    logic [2:0] key_fire;
    logic [HOLD_W-1:0] hold_target [3];
    logic [1:0] wiring_state_setting;
    logic [2:0] cur_range;
    logic [1:0] volt_range;
    logic alarm_lower;
    logic [10:0] feature_cycle_setting;
    logic [7:0] sens;
    logic [FEAT_W-1:0] crit_thr;
    logic [FEAT_W-1:0] warn_thr;
    logic [1:0] sel_idx;
    logic [HOLD_W-1:0] tick_cnt;
    logic [10:0] period_cnt;
    logic normal_got;
    logic abn_got;
    logic [FEAT_W-1:0] cand_chg [FEAT_N];
    logic [FEAT_W-1:0] cand_thr [FEAT_N];
    logic [1:0] best_idx;
    logic [FEAT_W-1:0] best_chg;

    // Two flops per key pin; only the second stage is read by logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_meta <= 3'h0;
            key_sync <= 3'h0;
        end else begin
            key_meta <= {set_key_i, normal_key_i, level_key_i};
            key_sync <= key_meta;
        end
    end

    assign hold_target[0] = (level == LVL_SETTING) ? HOLD_W'(SHORT_HOLD_CYCLES)
                                                   : HOLD_W'(LONG_HOLD_CYCLES);
    assign hold_target[1] = HOLD_W'(LONG_HOLD_CYCLES);
    assign hold_target[2] = HOLD_W'(LONG_HOLD_CYCLES);

    // One shot per press: a held key fires once, then waits for release
    for (genvar k = 0; k < 3; k++) begin : g_hold
        logic [HOLD_W-1:0] cnt;
        logic fired;
        wire reached = (cnt == hold_target[k] - HOLD_W'(1));
        always_ff @(posedge clk_i) begin
            if (rst_i || !key_sync[k]) begin
                cnt <= '0;
                fired <= 1'b0;
            end else if (!fired) begin
                if (reached) begin
                    fired <= 1'b1;
                end else begin
                    cnt <= cnt + HOLD_W'(1);
                end
            end
        end
        assign key_fire[k] = key_sync[k] && !fired && reached;
    end

    wire level_fire = key_fire[0];
    wire normal_fire = key_fire[1] && (level == LVL_OPERATION);
    wire set_fire = key_fire[2] && (level == LVL_OPERATION);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level <= LVL_OPERATION;
            setting_level_o <= 1'b0;
            soft_reset_o <= 1'b0;
        end else begin
            soft_reset_o <= 1'b0;
            setting_level_o <= level_fire ? (level == LVL_OPERATION) : (level == LVL_SETTING);
            if (level_fire) begin
                case (level)
                    LVL_OPERATION: level <= LVL_SETTING;
                    LVL_SETTING: begin
                        level <= LVL_OPERATION;
                        soft_reset_o <= 1'b1;
                    end
                    default: level <= LVL_OPERATION;
                endcase
            end
        end
    end

    // Wishbone slave: one wait state, ack for one cycle, unmapped reads return zero
    wire bus_req = cyc_i && stb_i && !ack_o;
    wire bus_wr = bus_req && we_i;
    wire in_setting = (level == LVL_SETTING);
    wire [31:0] settings_word = {19'h00000, alarm_lower, 2'h0, volt_range, 1'b0, cur_range,
                                 2'h0, wiring_state_setting};
    wire [31:0] set_w = lane_merge(settings_word, dat_i, sel_i);
    wire [31:0] cyc_w = lane_merge({21'h000000, feature_cycle_setting}, dat_i, sel_i);
    wire [31:0] sens_w = lane_merge({24'h000000, sens}, dat_i, sel_i);
    wire [31:0] crit_w = lane_merge({16'h0000, crit_thr}, dat_i, sel_i);
    wire [31:0] warn_w = lane_merge({16'h0000, warn_thr}, dat_i, sel_i);
    wire [1:0] wiring_in = set_w[SET_WIRING_LSB +: 2];
    wire [2:0] cur_in = set_w[SET_CUR_LSB +: 3];
    wire [1:0] volt_in = set_w[SET_VOLT_LSB +: 2];
    wire [10:0] cycle_in = cyc_w[10:0];
    wire [7:0] sens_in = sens_w[7:0];
    wire cycle_ok = (cyc_w[31:11] == 21'h000000) && (cycle_in >= CYCLE_MIN)
                    && (cycle_in <= CYCLE_MAX);
    wire sens_ok = (sens_w[31:8] == 24'h000000) && (sens_in >= SENS_MIN) && (sens_in <= SENS_MAX);
    wire wr_set = bus_wr && reg_hit(adr_i, ADDR_SETTINGS);
    wire [31:0] status_word = {16'h0000, 5'h00, alarm_out1_o, alarm_out2_o, lamp_green_o,
                               2'h0, teach_success_lamp_o, normal_capture_key_lamp_o,
                               abn_got, 2'(teach), setting_level_o};
    wire [31:0] rd_word = reg_hit(adr_i, ADDR_SETTINGS) ? settings_word :
                          reg_hit(adr_i, ADDR_CYCLE) ? {21'h000000, feature_cycle_setting} :
                          reg_hit(adr_i, ADDR_SENS) ? {24'h000000, sens} :
                          reg_hit(adr_i, ADDR_STATUS) ? status_word :
                          reg_hit(adr_i, ADDR_CRIT) ? {16'h0000, crit_thr} :
                          reg_hit(adr_i, ADDR_WARN) ? {16'h0000, warn_thr} :
                          reg_hit(adr_i, ADDR_SELECT) ? {30'h00000000, sel_idx} : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_word : 32'h00000000;
        end
    end

    // Input settings: out-of-range values are dropped so a stored code is always legal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wiring_state_setting <= WIRING_RST;
            cur_range <= CUR_RST;
            volt_range <= VOLT_RST;
            alarm_lower <= ATYPE_RST;
            feature_cycle_setting <= CYCLE_RST;
            sens <= SENS_RST;
        end else begin
            if (wr_set && in_setting && wiring_in <= SINGLE_PHASE_CURRENT) begin
                wiring_state_setting <= wiring_in;
            end
            if (wr_set && in_setting && cur_in <= CUR_CODE_MAX) begin
                cur_range <= cur_in;
            end
            if (wr_set && in_setting && volt_in <= VOLT_CODE_MAX) begin
                volt_range <= volt_in;
            end
            // Configuration tool path; the panel keys never reach this bit
            if (wr_set) begin
                alarm_lower <= set_w[SET_ATYPE_BIT];
            end
            if (bus_wr && reg_hit(adr_i, ADDR_CYCLE) && in_setting && cycle_ok) begin
                feature_cycle_setting <= cycle_in;
            end
            if (bus_wr && reg_hit(adr_i, ADDR_SENS) && in_setting && sens_ok) begin
                sens <= sens_in;
            end
        end
    end

    wire tick = (tick_cnt == HOLD_W'(TICK_CYCLES) - HOLD_W'(1));
    wire period_end = tick && (period_cnt == feature_cycle_setting - 11'h001);
    wire start_normal = normal_fire && (teach == TCH_IDLE || teach == TCH_DONE);
    wire enter_abn = (teach == TCH_NORMAL) && period_end && normal_got;
    wire commit = (teach == TCH_ABNORMAL) && set_fire && abn_got;

    // Per-feature extremes; upper alarms compare maxima, lower alarms minima
    for (genvar f = 0; f < FEAT_N; f++) begin : g_feat
        logic [FEAT_W-1:0] nmax, nmin, amax, amin;
        logic [FEAT_W-1:0] chg;
        logic [23:0] scaled;
        logic [FEAT_W:0] up_sum;
        always_ff @(posedge clk_i) begin
            if (rst_i || start_normal) begin
                nmax <= '0;
                nmin <= '1;
            end else if (teach == TCH_NORMAL && feat_valid_i) begin
                if (feat_i[f] > nmax) nmax <= feat_i[f];
                if (feat_i[f] < nmin) nmin <= feat_i[f];
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i || enter_abn) begin
                amax <= '0;
                amin <= '1;
            end else if (teach == TCH_ABNORMAL && feat_valid_i) begin
                if (feat_i[f] > amax) amax <= feat_i[f];
                if (feat_i[f] < amin) amin <= feat_i[f];
            end
        end
        assign chg = alarm_lower ? ((nmin > amin) ? nmin - amin : '0)
                                 : ((amax > nmax) ? amax - nmax : '0);
        // Threshold sits sens percent of the way from normal toward abnormal
        assign scaled = (24'(chg) * 24'(sens)) / PERCENT_DIV;
        assign up_sum = {1'b0, nmax} + (FEAT_W+1)'(scaled);
        assign cand_chg[f] = chg;
        assign cand_thr[f] = alarm_lower ? ((24'(nmin) > scaled) ? nmin - FEAT_W'(scaled) : '0)
                             : ((up_sum[FEAT_W] || scaled[23:FEAT_W] != '0) ? '1
                                : up_sum[FEAT_W-1:0]);
    end

    // Ties go to the lowest feature index
    always_comb begin
        best_idx = 2'h0;
        best_chg = cand_chg[0];
        for (int i = 1; i < FEAT_N; i++) begin
            if (cand_chg[i] > best_chg) begin
                best_chg = cand_chg[i];
                best_idx = 2'(i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || teach != TCH_NORMAL) begin
            tick_cnt <= '0;
            period_cnt <= 11'h000;
        end else if (tick) begin
            tick_cnt <= '0;
            period_cnt <= period_cnt + 11'h001;
        end else begin
            tick_cnt <= tick_cnt + HOLD_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_reset_o) begin
            teach <= TCH_IDLE;
            normal_capture_key_lamp_o <= 1'b0;
            teach_success_lamp_o <= 1'b0;
            normal_got <= 1'b0;
            abn_got <= 1'b0;
            sel_idx <= 2'h0;
        end else begin
            case (teach)
                TCH_IDLE, TCH_DONE: begin
                    if (start_normal) begin
                        teach <= TCH_NORMAL;
                        normal_capture_key_lamp_o <= 1'b0;
                        teach_success_lamp_o <= 1'b0;
                        normal_got <= 1'b0;
                    end
                end
                TCH_NORMAL: begin
                    if (feat_valid_i) normal_got <= 1'b1;
                    if (period_end) begin
                        teach <= normal_got ? TCH_ABNORMAL : TCH_IDLE;
                        normal_capture_key_lamp_o <= normal_got;
                        abn_got <= 1'b0;
                    end
                end
                TCH_ABNORMAL: begin
                    if (feat_valid_i) abn_got <= 1'b1;
                    if (commit) begin
                        teach <= TCH_DONE;
                        normal_capture_key_lamp_o <= 1'b0;
                        teach_success_lamp_o <= 1'b1;
                        sel_idx <= best_idx;
                    end
                end
                default: teach <= TCH_IDLE;
            endcase
        end
    end

    // Software may spread the two thresholds later; a completing teach overrides a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crit_thr <= '1;
            warn_thr <= '1;
        end else if (commit) begin
            crit_thr <= cand_thr[best_idx];
            warn_thr <= cand_thr[best_idx];
        end else begin
            if (bus_wr && reg_hit(adr_i, ADDR_CRIT)) crit_thr <= crit_w[FEAT_W-1:0];
            if (bus_wr && reg_hit(adr_i, ADDR_WARN)) warn_thr <= warn_w[FEAT_W-1:0];
        end
    end

    wire [FEAT_W-1:0] mon = feat_i[sel_idx];
    wire hit_crit = alarm_lower ? (mon <= crit_thr) : (mon >= crit_thr);
    wire hit_warn = alarm_lower ? (mon <= warn_thr) : (mon >= warn_thr);

    // Indicators stay dark until a teach has completed
    always_ff @(posedge clk_i) begin
        if (rst_i || teach != TCH_DONE) begin
            lamp_green_o <= 1'b0;
            lamp_yellow_o <= 1'b0;
            lamp_red_o <= 1'b0;
            alarm_out1_o <= 1'b0;
            alarm_out2_o <= 1'b0;
        end else if (feat_valid_i) begin
            lamp_red_o <= hit_crit;
            alarm_out1_o <= hit_crit;
            lamp_yellow_o <= !hit_crit && hit_warn;
            alarm_out2_o <= !hit_crit && hit_warn;
            lamp_green_o <= !hit_crit && !hit_warn;
        end else if (!lamp_red_o && !lamp_yellow_o && !lamp_green_o) begin
            lamp_green_o <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_setting_entry: assert property (level_fire && level == LVL_OPERATION |=> setting_level_o)
        else $error("level key hold did not enter setting level");
    chk_soft_reset: assert property ($fell(setting_level_o) |-> soft_reset_o ##1 teach == TCH_IDLE)
        else $error("leaving setting level without soft reset");
    chk_sens_range: assert property (sens >= SENS_MIN && sens <= SENS_MAX)
        else $error("sensitivity out of range");
    chk_alarm_gating: assert property (teach != TCH_DONE ##1 teach != TCH_DONE |->
                                       !alarm_out1_o && !alarm_out2_o && !lamp_green_o)
        else $error("alarm or indicator active before teaching completed");
    chk_red_alarm: assert property (alarm_out1_o |-> lamp_red_o && !lamp_green_o && !alarm_out2_o)
        else $error("critical status not shown as red with alarm 1");
    chk_yellow_alarm: assert property (alarm_out2_o |-> lamp_yellow_o && !lamp_red_o)
        else $error("warning status not shown as yellow with alarm 2");
    chk_lamp_swap: assert property ($rose(teach_success_lamp_o) |->
                                    $past(normal_capture_key_lamp_o) && !normal_capture_key_lamp_o)
        else $error("teach completion did not swap the lamps");
    chk_equal_thresh: assert property (commit |=> crit_thr == warn_thr && teach == TCH_DONE)
        else $error("thresholds differ at teach completion");
    chk_key_release: assert property (!key_sync[1] |=> g_hold[1].cnt == '0 && !key_fire[1])
        else $error("hold timer not restarted on release");

endmodule

// ==== ctm_operator.sv ====
// Purpose: Operator model: front-panel keys and feature samples for the teach control block
// Assumes: Keys are held as whole presses; features pulse valid for one cycle
// Notes: Feature lines go to the inverse pattern between samples, never a stale value
`timescale 1ns/1ps
module ctm_operator import ctm_pkg::*; (
    input wire logic clk_i,
    output logic level_key_o,
    output logic normal_key_o,
    output logic set_key_o,
    output logic feat_valid_o,
    output logic [FEAT_N-1:0][FEAT_W-1:0] feat_o
);
    initial begin
        level_key_o = 1'b0;
        normal_key_o = 1'b0;
        set_key_o = 1'b0;
        feat_valid_o = 1'b0;
        feat_o = '0;
    end

    // Key 0 level, 1 normal capture, 2 set; a short n releases early
    task automatic press(input int k, input int n);
        @(posedge clk_i);
        if (k == 0) level_key_o <= 1'b1;
        if (k == 1) normal_key_o <= 1'b1;
        if (k == 2) set_key_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        level_key_o <= 1'b0;
        normal_key_o <= 1'b0;
        set_key_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // Feature 2 is the one under test; the others wander a little around base
    task automatic sample(input logic [15:0] f2, input int base);
        @(posedge clk_i);
        feat_valid_o <= 1'b1;
        feat_o[0] <= 16'(base + $urandom % 10);
        feat_o[1] <= 16'(base + $urandom % 10);
        feat_o[2] <= f2;
        feat_o[3] <= 16'(base + $urandom % 10);
        @(posedge clk_i);
        feat_valid_o <= 1'b0;
        feat_o <= ~feat_o;
    endtask
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the teach control block
// Assumes: Hold counts shortened to 20/8 cycles and the 50 ms tick to 4 cycles
// Notes: Register reads are scored from a queue by a separate ack monitor
`timescale 1ns/1ps
module tb_top import ctm_pkg::*;;
    localparam int LONG = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic we_i = 1'b0;
    logic [3:0] sel_i = '0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic ack_o, level_key_i, normal_key_i, set_key_i, feat_valid_i;
    logic [FEAT_N-1:0][FEAT_W-1:0] feat_i;
    logic setting_level_o, soft_reset_o, normal_capture_key_lamp_o, teach_success_lamp_o;
    logic lamp_green_o, lamp_yellow_o, lamp_red_o, alarm_out1_o, alarm_out2_o;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_soft = 0;
    logic [31:0] exp_q[$];

    always #12.5 clk_i = ~clk_i;

    ctm_teach_control #(.LONG_HOLD_CYCLES(LONG), .SHORT_HOLD_CYCLES(8), .TICK_CYCLES(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .level_key_i(level_key_i), .normal_key_i(normal_key_i), .set_key_i(set_key_i),
        .feat_valid_i(feat_valid_i), .feat_i(feat_i), .setting_level_o(setting_level_o),
        .soft_reset_o(soft_reset_o), .normal_capture_key_lamp_o(normal_capture_key_lamp_o),
        .teach_success_lamp_o(teach_success_lamp_o), .lamp_green_o(lamp_green_o),
        .lamp_yellow_o(lamp_yellow_o), .lamp_red_o(lamp_red_o),
        .alarm_out1_o(alarm_out1_o), .alarm_out2_o(alarm_out2_o));

    ctm_operator i_op (.clk_i(clk_i), .level_key_o(level_key_i), .normal_key_o(normal_key_i),
        .set_key_o(set_key_i), .feat_valid_o(feat_valid_i), .feat_o(feat_i));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Classic single cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic lamps(input logic [6:0] exp);
        repeat (2) @(posedge clk_i);
        check("lamps", {normal_capture_key_lamp_o, teach_success_lamp_o, lamp_green_o,
            lamp_yellow_o, lamp_red_o, alarm_out2_o, alarm_out1_o}, 32'(exp));
    endtask

    // Read results are scored here as acks arrive, oldest note first
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (exp_q.size() == 0) check("unexpected ack", 32'h1, 32'h0);
            else check("read data", dat_o, exp_q.pop_front());
        end
        if (soft_reset_o === 1'b1) n_soft++;
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h120425eb));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_SETTINGS, 32'h0);
        rd(ADDR_CYCLE, 32'h1);
        rd(ADDR_SENS, 32'h50);
        rd(ADDR_CRIT, 32'hFFFF);
        rd(8'h1C, 32'h0);
        lamps(7'h00);
        $display("test reset values done");
        i_op.press(0, LONG - 8);
        check("level after short hold", 32'(setting_level_o), 32'h0);
        i_op.press(0, LONG + 6);
        check("level after long hold", 32'(setting_level_o), 32'h1);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, ADDR_SETTINGS, 32'((i % 3) << 8 | i << 4 | (i % 3)));
            rd(ADDR_SETTINGS, 32'((i % 3) << 8 | i << 4 | (i % 3)));
        end
        wb(1'b1, ADDR_SETTINGS, 32'h353);
        wb(1'b1, ADDR_CYCLE, 32'd2001);
        wb(1'b1, ADDR_SENS, 32'd19);
        rd(ADDR_SETTINGS, 32'h141);
        rd(ADDR_CYCLE, 32'h1);
        rd(ADDR_SENS, 32'h50);
        wb(1'b1, ADDR_CYCLE, 32'd10);
        wb(1'b1, ADDR_SENS, 32'd20);
        rd(ADDR_CYCLE, 32'd10);
        rd(ADDR_SENS, 32'd20);
        i_op.press(0, 14);
        check("soft reset pulses", 32'(n_soft), 32'h1);
        check("level after exit", 32'(setting_level_o), 32'h0);
        wb(1'b1, ADDR_SETTINGS, 32'h1000);
        rd(ADDR_SETTINGS, 32'h1141);
        wb(1'b1, ADDR_SETTINGS, 32'h0);
        rd(ADDR_SETTINGS, 32'h141);
        $display("test levels and settings done");
        // Normal running must outlast one 40-cycle feature period before the capture key
        repeat (5) begin
            i_op.sample(16'd100, 90);
            repeat (8) @(posedge clk_i);
        end
        i_op.press(1, LONG + 6);
        repeat (3) i_op.sample(16'd100, 90);
        repeat (40) @(posedge clk_i);
        lamps(7'h40);
        i_op.sample(16'd600, 100);
        i_op.sample(16'd400, 130);
        lamps(7'h40);
        i_op.press(2, LONG + 6);
        lamps(7'h30);
        // 100 + (600 - 100) * 20 / 100 with the low sensitivity
        rd(ADDR_CRIT, 32'd200);
        rd(ADDR_WARN, 32'd200);
        rd(ADDR_SELECT, 32'd2);
        rd(ADDR_STATUS, 32'h12E);
        $display("test teaching done");
        i_op.sample(16'(100 + $urandom % 50), 100);
        lamps(7'h30);
        wb(1'b1, ADDR_WARN, 32'd180);
        i_op.sample(16'd190, 100);
        lamps(7'h2A);
        i_op.sample(16'd250, 100);
        lamps(7'h25);
        $display("test alarm status done");
        summarize();
    end
endmodule
